// ==== logic/dcs_pkg.sv ====
// Purpose: Shared constants for the DMA channel control and status block
// Assumes: Nineteen channels, 32-bit system addresses
// Notes:   The shared widths, descriptor stride and per-channel reset values live here
package dcs_pkg;
    localparam int          NUM_CH      = 19;
    localparam int          CH_W        = 5;
    localparam int          ADDR_W      = 32;
    localparam int          WDATA_W     = 32;
    localparam int          DESC_SHIFT  = 4;
    localparam int          FIFO_DEPTH  = 16;
    localparam int          FETCH_W     = CH_W + ADDR_W;
    localparam int          PAD_W       = ADDR_W - CH_W - DESC_SHIFT;
    localparam logic [NUM_CH-1:0] CH_MASK     = 19'h7FFFF;
    localparam logic [NUM_CH-1:0] CH_RESET    = 19'h00000;
    localparam logic [ADDR_W-1:0] BASE_RESET  = 32'h00000000;
    localparam int          SUM_ACT_BIT = 0;
    localparam int          SUM_ERR_BIT = 1;
endpackage

// ==== logic/dcs_stream_if.sv ====
// Purpose: Valid and ready stream carrier between the block's own modules
// Assumes: One clock; data stands while valid is high and ready low
// Notes:   Width is set per instance
`timescale 1ns/1ns
interface dcs_stream_if #(
    parameter int WIDTH = 8
);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input  ready);
    modport snk (input  valid, input  data, output ready);
endinterface

// ==== logic/dcs_fifo.sv ====
// Purpose: Flip-flop FIFO with valid and ready on both sides
// Assumes: Synchronous active-low reset, clock enable freezes all state
// Notes:   Output data is read straight from the slot at the read index
`timescale 1ns/1ns
module dcs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic  i_core_clk,
    input  wire logic  i_rst_n,
    input  wire logic  i_clk_en,
    // Streams
    dcs_stream_if.snk  s_in,
    dcs_stream_if.src  s_out
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wr_q;
    logic [PW-1:0]    rd_q;
    logic [PW:0]      cnt_q;
    wire              full   = (cnt_q == (PW+1)'(DEPTH));
    wire              empty  = (cnt_q == '0);
    wire              do_wr  = s_in.valid && !full;
    wire              do_rd  = s_out.ready && !empty;

    assign s_in.ready  = !full;
    assign s_out.valid = !empty;
    assign s_out.data  = mem_q[rd_q];

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else if (i_clk_en) begin
            if (do_wr) begin
                mem_q[wr_q] <= s_in.data;
                wr_q        <= wr_q + 1'b1;
            end
            if (do_rd) begin
                rd_q <= rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (PW+1)'(do_wr) - (PW+1)'(do_rd);
        end
    end

    AST_FIFO_NO_OVERRUN: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        cnt_q <= (PW+1)'(DEPTH))
        else $error("fifo count above depth");
endmodule

// ==== logic/dcs_channel_ctrl.sv ====
// Purpose: Channel enables, status flags, interrupt flags and descriptor sequencing
// Assumes: Register writes arrive as one-cycle strobes with shared data
// Notes:   Datapath events arrive as one-cycle per-channel pulses
`timescale 1ns/1ns
module dcs_channel_ctrl (
    // Clock and reset
    input  wire logic                          i_core_clk,
    input  wire logic                          i_rst_n,
    input  wire logic                          i_clk_en,
    // Control settings
    input  wire logic                          i_global_enable,
    input  wire logic [dcs_pkg::ADDR_W-1:0]    i_descriptor_table_base,
    // Register write strobes and shared data
    input  wire logic [dcs_pkg::WDATA_W-1:0]   i_wr_data,
    input  wire logic                          i_channel_enable_set_wr,
    input  wire logic                          i_channel_enable_clear_wr,
    input  wire logic                          i_channel_error_flags_wr,
    input  wire logic                          i_irq_enable_set_wr,
    input  wire logic                          i_irq_enable_clear_wr,
    input  wire logic                          i_irq_a_flags_wr,
    input  wire logic                          i_irq_b_flags_wr,
    input  wire logic                          i_set_valid_strobe_wr,
    input  wire logic                          i_set_trigger_strobe_wr,
    input  wire logic                          i_abort_strobe_wr,
    // Datapath events, one-cycle pulses per channel
    input  wire logic [dcs_pkg::NUM_CH-1:0]    i_op_start,
    input  wire logic [dcs_pkg::NUM_CH-1:0]    i_pipe_issue,
    input  wire logic [dcs_pkg::NUM_CH-1:0]    i_pipe_drained,
    input  wire logic [dcs_pkg::NUM_CH-1:0]    i_error_event,
    input  wire logic [dcs_pkg::NUM_CH-1:0]    i_desc_exhausted,
    input  wire logic [dcs_pkg::NUM_CH-1:0]    i_exh_reload,
    input  wire logic [dcs_pkg::NUM_CH-1:0]    i_raise_irq_a_cfg,
    input  wire logic [dcs_pkg::NUM_CH-1:0]    i_raise_irq_b_cfg,
    input  wire logic [dcs_pkg::NUM_CH-1:0]    i_desc_met,
    input  wire logic [dcs_pkg::NUM_CH-1:0]    i_descriptor_valid_cfg,
    input  wire logic [dcs_pkg::NUM_CH-1:0]    i_trigger_consumed,
    input  wire logic [dcs_pkg::NUM_CH-1:0]    i_fetch_req,
    // Descriptor fetch stream
    input  wire logic                          i_fetch_ready,
    output logic                               o_fetch_valid,
    output logic [dcs_pkg::CH_W-1:0]           o_fetch_chan,
    output logic [dcs_pkg::ADDR_W-1:0]         o_fetch_addr,
    output logic [dcs_pkg::NUM_CH-1:0]         o_fetch_grant,
    // Channel control towards the datapath
    output logic [dcs_pkg::NUM_CH-1:0]         o_channel_run,
    output logic [dcs_pkg::NUM_CH-1:0]         o_desc_go,
    output logic [dcs_pkg::NUM_CH-1:0]         o_desc_paused,
    output logic [dcs_pkg::NUM_CH-1:0]         o_abort_pulse,
    // Readable status
    output logic [dcs_pkg::NUM_CH-1:0]         o_channel_enable_set,
    output logic [dcs_pkg::NUM_CH-1:0]         o_channel_active_flags,
    output logic [dcs_pkg::NUM_CH-1:0]         o_channel_busy_flags,
    output logic [dcs_pkg::NUM_CH-1:0]         o_channel_error_flags,
    output logic [dcs_pkg::NUM_CH-1:0]         o_irq_enable_set,
    output logic [dcs_pkg::NUM_CH-1:0]         o_irq_a_flags,
    output logic [dcs_pkg::NUM_CH-1:0]         o_irq_b_flags,
    output logic [dcs_pkg::NUM_CH-1:0]         o_buffered_valid_request,
    output logic [dcs_pkg::NUM_CH-1:0]         o_trigger_pending,
    output logic [1:0]                         o_interrupt_summary,
    output logic                               o_dma_irq
);
    localparam int N = dcs_pkg::NUM_CH;

    function automatic logic [dcs_pkg::CH_W-1:0] first_set(input logic [N-1:0] v);
        logic [dcs_pkg::CH_W-1:0] idx;
        idx = '0;
        for (int k = N - 1; k >= 0; k--) begin
            if (v[k]) begin
                idx = dcs_pkg::CH_W'(k);
            end
        end
        return idx;
    endfunction

    function automatic logic [N-1:0] strobe(input logic wr, input logic [dcs_pkg::WDATA_W-1:0] d);
        return wr ? (d[N-1:0] & dcs_pkg::CH_MASK) : '0;
    endfunction

    // State registers
    logic [N-1:0] en_q, en_d;
    logic [N-1:0] act_q, act_d;
    logic [N-1:0] busy_q, busy_d;
    logic [N-1:0] end_q, end_d;
    logic [N-1:0] err_q, err_d;
    logic [N-1:0] ie_q, ie_d;
    logic [N-1:0] ia_q, ia_d;
    logic [N-1:0] ib_q, ib_d;
    logic [N-1:0] sv_q, sv_d;
    logic [N-1:0] trg_q, trg_d;
    logic [N-1:0] pau_q, pau_d;
    logic [N-1:0] go_q, go_d;
    logic [N-1:0] run_q, run_d;
    logic [N-1:0] abt_q;
    logic [N-1:0] fpend_q, fpend_d;
    logic [N-1:0] grant_q, grant_d;
    logic [1:0]   sum_q, sum_d;
    logic         irq_q, irq_d;

    // Masked write strobes; bits above the last channel never reach state
    wire [N-1:0] w_ens  = strobe(i_channel_enable_set_wr, i_wr_data);
    wire [N-1:0] w_enc  = strobe(i_channel_enable_clear_wr, i_wr_data);
    wire [N-1:0] w_err  = strobe(i_channel_error_flags_wr, i_wr_data);
    wire [N-1:0] w_ies  = strobe(i_irq_enable_set_wr, i_wr_data);
    wire [N-1:0] w_iec  = strobe(i_irq_enable_clear_wr, i_wr_data);
    wire [N-1:0] w_ia   = strobe(i_irq_a_flags_wr, i_wr_data);
    wire [N-1:0] w_ib   = strobe(i_irq_b_flags_wr, i_wr_data);
    wire [N-1:0] w_sv   = strobe(i_set_valid_strobe_wr, i_wr_data);
    wire [N-1:0] w_trg  = strobe(i_set_trigger_strobe_wr, i_wr_data);
    wire [N-1:0] w_abt  = strobe(i_abort_strobe_wr, i_wr_data);

    // Enables: set then clear; clearing touches nothing else so the channel resumes
    assign en_d  = (en_q | w_ens) & ~w_enc;
    assign ie_d  = (ie_q | w_ies) & ~w_iec;
    assign run_d = en_d & {N{i_global_enable}};

    // Busy is a flag set by pipeline issue and cleared by drain or abort; a new issue wins over drain
    assign busy_d = (busy_q & ~i_pipe_drained & ~w_abt) | i_pipe_issue;

    // Active lasts from start until the final no-reload descriptor has drained
    wire [N-1:0] last_exh = i_desc_exhausted & ~i_exh_reload;
    assign end_d = ((end_q | last_exh) & ~i_op_start) & ~w_abt;
    wire [N-1:0] drained_end = end_q & ~busy_q & ~i_pipe_issue;
    assign act_d = ((act_q & ~drained_end) & ~w_abt) | i_op_start;

    // Interrupt flags: a hardware set in the clearing cycle is kept
    wire [N-1:0] set_a = i_desc_exhausted & i_raise_irq_a_cfg;
    wire [N-1:0] set_b = i_desc_exhausted & i_raise_irq_b_cfg;
    assign err_d = (err_q & ~w_err) | i_error_event;
    assign ia_d  = (ia_q & ~w_ia) | set_a;
    assign ib_d  = (ib_q & ~w_ib) | set_b;

    // Interrupt output and summary
    wire [N-1:0] ab_pend = (ia_d | ib_d) & ie_d;
    assign irq_d = (|err_d) | (|ab_pend);
    assign sum_d[dcs_pkg::SUM_ACT_BIT] = |ab_pend;
    assign sum_d[dcs_pkg::SUM_ERR_BIT] = |err_d;

    // Descriptor valid sequencing
    wire [N-1:0] met_ok   = i_desc_met & i_descriptor_valid_cfg;
    wire [N-1:0] met_bad  = i_desc_met & ~i_descriptor_valid_cfg;
    wire [N-1:0] use_buf  = met_bad & sv_q;
    wire [N-1:0] use_new  = met_bad & ~sv_q & w_sv;
    wire [N-1:0] resume   = pau_q & w_sv;
    wire [N-1:0] new_pau  = met_bad & ~sv_q & ~w_sv;
    wire [N-1:0] sv_taken = use_new | resume;
    assign go_d  = (met_ok | use_buf | use_new | resume) & ~w_abt;
    assign pau_d = ((pau_q & ~resume) | new_pau) & ~w_abt;
    assign sv_d  = ((sv_q & ~use_buf) | (w_sv & ~sv_taken)) & ~w_abt;

    // Trigger pending: a software set wins over the datapath consuming it
    assign trg_d = ((trg_q & ~i_trigger_consumed) & ~w_abt) | w_trg;

    // Fetch carriers come first so the push logic below can see the FIFO ready
    dcs_stream_if #(.WIDTH(dcs_pkg::FETCH_W)) fifo_in  ();
    dcs_stream_if #(.WIDTH(dcs_pkg::FETCH_W)) fifo_out ();

    // Descriptor fetch arbitration, lowest channel first, only channels in use
    wire [N-1:0] fpend_all = fpend_q | i_fetch_req;
    wire [N-1:0] fcand     = fpend_q & run_q;
    wire         fpush     = (|fcand) && fifo_in.ready;
    wire [dcs_pkg::CH_W-1:0] fch = first_set(fcand);
    wire [N-1:0] fhot      = fpush ? (N'(1) << fch) : '0;
    wire [dcs_pkg::ADDR_W-1:0] faddr = i_descriptor_table_base
        + {{dcs_pkg::PAD_W{1'b0}}, fch, {dcs_pkg::DESC_SHIFT{1'b0}}};
    assign fpend_d = (fpend_all & ~fhot) & ~w_abt;
    assign grant_d = fhot;

    assign fifo_in.valid  = |fcand;
    assign fifo_in.data   = {fch, faddr};
    assign fifo_out.ready = i_fetch_ready;

    dcs_fifo #(
        .WIDTH (dcs_pkg::FETCH_W),
        .DEPTH (dcs_pkg::FIFO_DEPTH)
    ) u_fetch_fifo (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_clk_en   (i_clk_en),
        .s_in       (fifo_in),
        .s_out      (fifo_out)
    );

    assign o_fetch_valid = fifo_out.valid;
    assign o_fetch_chan  = fifo_out.data[dcs_pkg::FETCH_W-1:dcs_pkg::ADDR_W];
    assign o_fetch_addr  = fifo_out.data[dcs_pkg::ADDR_W-1:0];

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            en_q    <= dcs_pkg::CH_RESET;
            ie_q    <= dcs_pkg::CH_RESET;
            run_q   <= dcs_pkg::CH_RESET;
            busy_q  <= dcs_pkg::CH_RESET;
            end_q   <= dcs_pkg::CH_RESET;
            act_q   <= dcs_pkg::CH_RESET;
            err_q   <= dcs_pkg::CH_RESET;
            ia_q    <= dcs_pkg::CH_RESET;
            ib_q    <= dcs_pkg::CH_RESET;
            go_q    <= dcs_pkg::CH_RESET;
            pau_q   <= dcs_pkg::CH_RESET;
            sv_q    <= dcs_pkg::CH_RESET;
            trg_q   <= dcs_pkg::CH_RESET;
            abt_q   <= dcs_pkg::CH_RESET;
            fpend_q <= dcs_pkg::CH_RESET;
            grant_q <= dcs_pkg::CH_RESET;
            sum_q   <= 2'h0;
            irq_q   <= 1'b0;
        end else if (i_clk_en) begin
            en_q    <= en_d;
            ie_q    <= ie_d;
            run_q   <= run_d;
            busy_q  <= busy_d;
            end_q   <= end_d;
            act_q   <= act_d;
            err_q   <= err_d;
            ia_q    <= ia_d;
            ib_q    <= ib_d;
            go_q    <= go_d;
            pau_q   <= pau_d;
            sv_q    <= sv_d;
            trg_q   <= trg_d;
            abt_q   <= w_abt;
            fpend_q <= fpend_d;
            grant_q <= grant_d;
            sum_q   <= sum_d;
            irq_q   <= irq_d;
        end
    end

    assign o_channel_enable_set     = en_q;
    assign o_irq_enable_set         = ie_q;
    assign o_channel_run            = run_q;
    assign o_channel_busy_flags     = busy_q;
    assign o_channel_active_flags   = act_q;
    assign o_channel_error_flags    = err_q;
    assign o_irq_a_flags            = ia_q;
    assign o_irq_b_flags            = ib_q;
    assign o_desc_go                = go_q;
    assign o_desc_paused            = pau_q;
    assign o_buffered_valid_request = sv_q;
    assign o_trigger_pending        = trg_q;
    assign o_abort_pulse            = abt_q;
    assign o_fetch_grant            = grant_q;
    assign o_interrupt_summary      = sum_q;
    assign o_dma_irq                = irq_q;

    // Checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    AST_ENABLE_SET: assert property (
        i_clk_en && i_channel_enable_set_wr && !i_channel_enable_clear_wr
        |=> (o_channel_enable_set & $past(i_wr_data[N-1:0])) == $past(i_wr_data[N-1:0]))
        else $error("enable set write did not enable channel");
    AST_ENABLE_CLEAR: assert property (
        i_clk_en && i_channel_enable_clear_wr
        |=> (o_channel_enable_set & $past(i_wr_data[N-1:0])) == '0)
        else $error("enable clear write left channel enabled");
    // Pause state and buffered requests must survive a disable untouched
    AST_DISABLE_KEEPS: assert property (
        i_clk_en && i_channel_enable_clear_wr && !i_abort_strobe_wr
        && !i_set_valid_strobe_wr && i_desc_met == '0
        |=> o_buffered_valid_request == $past(o_buffered_valid_request)
        && o_desc_paused == $past(o_desc_paused))
        else $error("disable disturbed channel state");
    AST_GLOBAL_GATE: assert property (
        i_clk_en && !i_global_enable |=> o_channel_run == '0)
        else $error("channel runs while global enable clear");
    AST_ERR_IRQ: assert property (
        o_channel_error_flags != '0 |-> o_dma_irq || $past(!i_clk_en))
        else $error("error flag pending without interrupt");
    AST_ERR_SET: assert property (
        i_clk_en && i_error_event[0] |=> o_channel_error_flags[0])
        else $error("error event lost");
    AST_ERR_CLEAR: assert property (
        i_clk_en && i_channel_error_flags_wr && i_wr_data[0] && !i_error_event[0]
        |=> !o_channel_error_flags[0])
        else $error("error flag not cleared by write one");
    AST_IRQ_EN_SET: assert property (
        i_clk_en && i_irq_enable_set_wr && !i_irq_enable_clear_wr
        |=> (o_irq_enable_set & $past(i_wr_data[N-1:0])) == $past(i_wr_data[N-1:0]))
        else $error("interrupt enable set write lost");
    AST_IRQ_EN_CLEAR: assert property (
        i_clk_en && i_irq_enable_clear_wr
        |=> (o_irq_enable_set & $past(i_wr_data[N-1:0])) == '0)
        else $error("interrupt enable clear write lost");
    AST_A_FLAG: assert property (
        i_clk_en && i_desc_exhausted[0] && i_raise_irq_a_cfg[0] |=> o_irq_a_flags[0])
        else $error("A flag not set on exhaustion");
    AST_B_FLAG: assert property (
        i_clk_en && i_desc_exhausted[0] && i_raise_irq_b_cfg[0] |=> o_irq_b_flags[0])
        else $error("B flag not set on exhaustion");
    AST_IRQ_MASK: assert property (
        i_clk_en ##1 (o_channel_error_flags == '0
        && ((o_irq_a_flags | o_irq_b_flags) & o_irq_enable_set) == '0) |-> !o_dma_irq)
        else $error("interrupt without enabled cause");
    AST_SV_BUFFER: assert property (
        i_clk_en && i_set_valid_strobe_wr && i_wr_data[0] && !o_desc_paused[0]
        && !i_desc_met[0] && !i_abort_strobe_wr |=> o_buffered_valid_request[0])
        else $error("set valid not buffered");
    AST_GO_VALID: assert property (
        i_clk_en && i_desc_met[0] && i_descriptor_valid_cfg[0] && !i_abort_strobe_wr
        |=> o_desc_go[0])
        else $error("valid descriptor did not run");
    AST_PAUSE_RESUME: assert property (
        i_clk_en && o_desc_paused[0] && i_set_valid_strobe_wr && i_wr_data[0]
        && !i_abort_strobe_wr
        |=> o_desc_go[0] && !o_desc_paused[0] && !o_buffered_valid_request[0])
        else $error("paused channel did not resume on set valid");
    AST_TRIGGER_PENDING_SET: assert property (
        i_clk_en && i_set_trigger_strobe_wr && i_wr_data[0] |=> o_trigger_pending[0])
        else $error("trigger pending not set");
    AST_ABORT: assert property (
        i_clk_en && i_abort_strobe_wr && i_wr_data[0] && !i_op_start[0]
        |=> !o_channel_active_flags[0] && !o_desc_paused[0] && o_abort_pulse[0])
        else $error("abort left channel state behind");
    AST_ACTIVE_START: assert property (
        i_clk_en && i_op_start[0] |=> o_channel_active_flags[0])
        else $error("active not set on start");
    AST_BUSY_ISSUE: assert property (
        i_clk_en && i_pipe_issue[0] |=> o_channel_busy_flags[0])
        else $error("busy not set on issue");
    AST_FETCH_ADDR: assert property (
        o_fetch_valid |-> o_fetch_addr[3:0] == 4'h0 || i_descriptor_table_base[3:0] != 4'h0)
        else $error("descriptor address off stride");
    // A grant may only go to a channel that was running when it was pushed
    AST_FETCH_RUN: assert property (
        o_fetch_grant != '0 && $past(i_clk_en)
        |-> (o_fetch_grant & ~$past(o_channel_run)) == '0)
        else $error("fetch granted to idle channel");
    AST_FETCH_ONE: assert property (
        $onehot0(o_fetch_grant))
        else $error("more than one fetch per cycle");
endmodule

// ==== testbench/dcs_fetch_sink.sv ====
// Purpose: Descriptor fetch sink standing in for the system memory bus
// Assumes: A fetch entry is taken when valid and ready meet at a rising edge
// Notes:   Ready wanders pseudo-randomly, so the FIFO also meets slow answers
`timescale 1ns/1ns
module dcs_fetch_sink (
    // Clock and reset
    input  wire logic i_core_clk,
    input  wire logic i_rst_n,
    // Control from the bench
    input  wire logic i_stall,
    // Fetch stream
    input  wire logic i_fetch_valid,
    output logic      o_fetch_ready,
    output logic      o_pop
);
    logic [31:0] lfsr_q;
    logic [31:0] lfsr_d;
    logic        ready_q;
    assign lfsr_d        = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    assign o_fetch_ready = ready_q;
    assign o_pop         = i_fetch_valid & ready_q;
    // Ready is a flop, so it never follows valid within the same cycle
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            lfsr_q  <= 32'h00000001;
            ready_q <= 1'h0;
        end else begin
            lfsr_q  <= lfsr_d;
            ready_q <= !i_stall && (lfsr_d[1:0] != 2'h0);
        end
    end
endmodule

// ==== testbench/testbench.sv ====
// Purpose: Self-checking bench for the DMA channel control and status block
// Assumes: Strobes and events are one-cycle pulses launched at a rising edge
// Notes:   Random data comes from an LFSR with a fixed start value
`timescale 1ns/1ns
module testbench;
    logic        clk = 1'h0, rst_n = 1'h0, glob = 1'h0, stall = 1'h0;
    logic        rl = 1'h0, ra = 1'h0, rb = 1'h0, cv = 1'h0, ce = 1'h1;
    logic [9:0]  stb = '0;
    logic [18:0] ev [8] = '{default: '0};
    logic [31:0] wdat = '0, base = '0, r = 32'h5896C7D6;
    logic [18:0] en = '0, ie = '0, m;
    logic [18:0] o_en, o_run, go, pau, abp, act, bsy, erf, oie, fa, fb, bv, tp, gr;
    logic [1:0]  sum;
    logic        irq, fv, rdy, pop;
    logic [4:0]  fch;
    logic [31:0] fad;
    int          err_total = 0, total_checks = 0, pops = 0;

    always #20 clk = ~clk;

    dcs_channel_ctrl dcs_channel_ctrl_i (
        .i_core_clk(clk), .i_rst_n(rst_n), .i_clk_en(ce), .i_global_enable(glob),
        .i_descriptor_table_base(base), .i_wr_data(wdat),
        .i_channel_enable_set_wr(stb[0]), .i_channel_enable_clear_wr(stb[1]),
        .i_channel_error_flags_wr(stb[2]), .i_irq_enable_set_wr(stb[3]),
        .i_irq_enable_clear_wr(stb[4]), .i_irq_a_flags_wr(stb[5]), .i_irq_b_flags_wr(stb[6]),
        .i_set_valid_strobe_wr(stb[7]), .i_set_trigger_strobe_wr(stb[8]),
        .i_abort_strobe_wr(stb[9]), .i_op_start(ev[0]), .i_pipe_issue(ev[1]),
        .i_pipe_drained(ev[2]), .i_error_event(ev[3]), .i_desc_exhausted(ev[4]),
        .i_exh_reload({19{rl}}), .i_raise_irq_a_cfg({19{ra}}), .i_raise_irq_b_cfg({19{rb}}),
        .i_desc_met(ev[5]), .i_descriptor_valid_cfg({19{cv}}), .i_trigger_consumed(ev[6]),
        .i_fetch_req(ev[7]), .i_fetch_ready(rdy), .o_fetch_valid(fv), .o_fetch_chan(fch),
        .o_fetch_addr(fad), .o_fetch_grant(gr), .o_channel_run(o_run), .o_desc_go(go),
        .o_desc_paused(pau), .o_abort_pulse(abp), .o_channel_enable_set(o_en),
        .o_channel_active_flags(act), .o_channel_busy_flags(bsy),
        .o_channel_error_flags(erf), .o_irq_enable_set(oie), .o_irq_a_flags(fa),
        .o_irq_b_flags(fb), .o_buffered_valid_request(bv), .o_trigger_pending(tp),
        .o_interrupt_summary(sum), .o_dma_irq(irq));

    dcs_fetch_sink dcs_fetch_sink_i (.i_core_clk(clk), .i_rst_n(rst_n), .i_stall(stall),
        .i_fetch_valid(fv), .o_fetch_ready(rdy), .o_pop(pop));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
        total_checks++;
        if (s !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic wr(input int k, input logic [31:0] d);
        @(posedge clk);
        stb[k] <= 1'h1;
        wdat   <= d;
        @(posedge clk);
        stb[k] <= 1'h0;
        #1;
    endtask

    task automatic evt(input int k, input logic [18:0] v);
        @(posedge clk);
        ev[k] <= v;
        @(posedge clk);
        ev[k] <= '0;
        #1;
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Fetch entries leave lowest channel first, so the pop count names the channel
    always @(posedge clk) begin
        if (rst_n && pop) begin
            chk("fetch_chan", fch, pops);
            chk("fetch_addr", fad, base + 32'(pops) * 32'h10);
            pops++;
        end
    end

    // Whole run takes well under a thousand cycles; ten thousand means a hang
    initial begin
        #400000;
        err_total++;
        test_done();
    end

    initial begin
        int k;
        repeat (16) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        #1;
        chk("reset", {o_en | act | bsy | erf | fa | fb | bv | tp, irq, sum, fv}, 0);
        for (int i = 0; i < 16; i++) begin
            r = lfsr(r);
            k = (i % 2) + 3 * ((i / 2) % 2);
            @(posedge clk) glob <= r[31];
            wr(k, r);
            case (k)
                0: en = en | r[18:0];
                1: en = en & ~r[18:0];
                3: ie = ie | r[18:0];
                default: ie = ie & ~r[18:0];
            endcase
            chk("enable", o_en, en);
            chk("run", o_run, en & {19{r[31]}});
            chk("irq_enable", oie, ie);
        end
        $display("test enables done");
        for (int j = 0; j < 6; j++) begin
            r = lfsr(r);
            m = (j < 3) ? 19'h00001 : 19'h00001 << (r % 19);
            wr((j % 2) ? 4 : 3, m);
            ie = (j % 2) ? ie & ~m : ie | m;
            k = j % 3;
            @(posedge clk) {ra, rb} <= {k == 1, k == 2};
            evt((k == 0) ? 3 : 4, m);
            chk("err", erf, (k == 0) ? m : 0);
            chk("flag_a", fa, (k == 1) ? m : 0);
            chk("flag_b", fb, (k == 2) ? m : 0);
            chk("irq", {sum, irq}, {k == 0, k != 0 && (ie & m) != 0, k == 0 || (ie & m) != 0});
            k = (k == 0) ? 2 : k + 4;
            wr(k, ~m);
            chk("w1c_zero", erf | fa | fb, m);
            wr(k, m);
            chk("w1c_one", {erf | fa | fb, irq, sum}, 0);
        end
        $display("test flags done");
        m = m | 19'h00001;
        @(posedge clk) {ra, rb, cv} <= 3'h1;
        evt(5, m);
        chk("go_valid", {go, pau}, {m, 19'h00000});
        @(posedge clk) cv <= 1'h0;
        evt(5, m);
        chk("paused", {go, pau}, {19'h00000, m});
        wr(7, m);
        chk("resume", {go, pau | bv}, {m, 19'h00000});
        wr(7, m);
        chk("buffered", bv, m);
        evt(5, m);
        chk("use_buffer", {go, pau | bv}, {m, 19'h00000});
        $display("test valid done");
        wr(8, m);
        chk("trigger", tp, m);
        evt(6, m);
        chk("trigger_pending_used", tp, 0);
        wr(8, m);
        evt(0, m);
        evt(1, m);
        chk("act_busy", {act, bsy}, {m, m});
        wr(1, m);
        en = en & ~m;
        chk("disabled", {act, bsy, o_en}, {m, m, en});
        evt(4, m);
        chk("act_hold", act, m);
        evt(2, m);
        repeat (2) @(posedge clk);
        #1;
        chk("act_end", {act, bsy}, 0);
        evt(0, m);
        evt(1, m);
        @(posedge clk) rl <= 1'h1;
        evt(4, m);
        evt(2, m);
        chk("act_reload", act, m);
        for (int i = 0; i < 50 && (bsy & m) != 0; i++) @(posedge clk);
        wr(9, m);
        chk("abort", {abp, act | bsy | tp | pau | bv}, {m, 19'h00000});
        chk("abort_keep", o_en, en);
        @(posedge clk) ce <= 1'h0;
        wr(1, 32'h0007FFFF);
        chk("frozen", o_en, en);
        @(posedge clk) ce <= 1'h1;
        $display("test abort done");
        wr(0, 32'h0007FFFF);
        @(posedge clk);
        glob  <= 1'h1;
        stall <= 1'h1;
        base  <= lfsr(r);
        evt(7, 19'h7FFFF);
        repeat (40) @(posedge clk);
        #1;
        chk("stalled", {pops, fv}, {32'h00000000, 1'h1});
        stall <= 1'h0;
        for (int i = 0; i < 400 && pops < 19; i++) @(posedge clk);
        #1;
        chk("drained", pops, 19);
        $display("test fetch done");
        test_done();
    end
endmodule
